// *** src/interrupt_vector_mapper.sv ***
`timescale 1ns/1ns
// Notes on behaviour
// - each external request can be taken on a rising edge or while held at its active level.
// - the table base comes from a software-written pointer, not a fixed place.
// - the base sits on a 256-word boundary and the slot lives in the low eight address bits.
// - the reset fetch is always from address zero, whatever the pointer holds.
// - external 0..3 use slots 01h..04h, serial 05h/06h, timers 09h/0Ah, dma 0Bh/0Ch.
// - software traps 0..31 use slots 20h..3Fh.
module interrupt_vector_mapper
    import vector_map_pkg::*;
(
    input wire logic clock,
    input wire logic resetn,
    input wire logic enable,
    input wire logic [NUM_EXT-1:0] externalRequest,
    input wire logic [NUM_EXT-1:0] edgeMode,
    input wire request_t peripheralRequest,
    input wire logic baseWrite,
    input wire logic [ADDR_W-1:0] baseData,
    input wire logic trapRequest,
    input wire logic [TRAP_W-1:0] trapNumber,
    input wire logic fetchReady,
    output logic [NUM_SRC-1:0] pendingSources,
    output logic [ADDR_W-1:0] vectorTableBasePointer,
    output fetch_t fetch,
    output logic [NUM_SRC-1:0] takenSource
);

    // ----------------------------------------
    // slot lookup
    // ----------------------------------------
    function automatic logic [SLOT_W-1:0] slot_of(input int idx);
        case (idx)
            0, 1, 2, 3: slot_of = SLOT_EXT0 + SLOT_W'(idx);
            4: slot_of = SLOT_SER_TX;
            5: slot_of = SLOT_SER_RX;
            6: slot_of = SLOT_TIMER0;
            7: slot_of = SLOT_TIMER1;
            8: slot_of = SLOT_DMA0;
            default: slot_of = SLOT_DMA1;
        endcase
    endfunction

    // ----------------------------------------
    // external request conditioning
    // ----------------------------------------
    logic [NUM_EXT-1:0] extPending;
    logic [NUM_EXT-1:0] extClear;

    edge_level_detect #(
        .WIDTH(NUM_EXT)
    ) u_detect (
        .clock(clock),
        .resetn(resetn),
        .enable(enable),
        .pin(externalRequest),
        .edgeMode(edgeMode),
        .clear(extClear),
        .pending(extPending)
    );

    assign pendingSources = {peripheralRequest[NUM_SRC-1:NUM_EXT], extPending};

    // ----------------------------------------
    // fetch sequencer
    // ----------------------------------------
    typedef enum logic [2:0] {
        S_RESET = 3'b001,
        S_IDLE = 3'b010,
        S_FETCH = 3'b100
    } state_t;

    state_t state, next_state;
    logic [BASE_W-1:0] base, next_base;
    logic [ADDR_W-1:0] addr, next_addr;
    logic [NUM_SRC-1:0] taken, next_taken;
    logic [NUM_SRC-1:0] pick;

    // lowest numbered pending source wins
    always_comb begin
        pick = '0;
        for (int i = NUM_SRC - 1; i >= 0; i--) begin
            if (pendingSources[i]) begin
                pick = NUM_SRC'(1) << i;
            end
        end
    end

    // next state, base and address
    always_comb begin
        next_state = state;
        next_base = base;
        next_addr = addr;
        next_taken = '0;
        if (baseWrite) begin
            next_base = baseData[ADDR_W-1:SLOT_W];
        end
        case (state)
            S_RESET: begin
                next_addr = RESET_VECTOR;
                if (fetchReady) begin
                    next_state = S_IDLE;
                end
            end
            S_IDLE: begin
                if (trapRequest) begin
                    next_addr = {base, SLOT_TRAP_FIRST + SLOT_W'(trapNumber)};
                    next_state = S_FETCH;
                end else if (|pick) begin
                    for (int i = 0; i < NUM_SRC; i++) begin
                        if (pick[i]) begin
                            next_addr = {base, slot_of(i)};
                        end
                    end
                    next_taken = pick;
                    next_state = S_FETCH;
                end
            end
            S_FETCH: begin
                if (fetchReady) begin
                    next_state = S_IDLE;
                end
            end
            default: next_state = S_RESET;
        endcase
    end

    assign extClear = next_taken[NUM_EXT-1:0];

    // state registers
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            state <= S_RESET;
            base <= BASE_RESET;
            addr <= RESET_VECTOR;
            taken <= '0;
        end else if (enable) begin
            state <= next_state;
            base <= next_base;
            addr <= next_addr;
            taken <= next_taken;
        end
    end

    assign fetch.valid = (state != S_IDLE);
    assign fetch.addr = addr;
    assign takenSource = taken;
    assign vectorTableBasePointer = {base, SLOT_W'(0)};

    // ----------------------------------------
    // checks
    // ----------------------------------------
    // a trap taken from idle
    sequence trap_taken;
        state == S_IDLE && trapRequest && enable;
    endsequence

    // a pending source taken from idle, no trap in the way
    sequence source_taken;
        state == S_IDLE && !trapRequest && (|pendingSources) && enable;
    endsequence

    // the processor accepts the standing fetch
    sequence fetch_accepted;
        state == S_FETCH && fetchReady && enable;
    endsequence

    a_reset_vector_zero: assert property (@(posedge clock) disable iff (!resetn)
        state == S_RESET |-> fetch.addr == 24'h00_0000)
        else $error("reset fetch not at zero");

    a_base_aligned: assert property (@(posedge clock) disable iff (!resetn)
        vectorTableBasePointer[7:0] == 8'h00)
        else $error("table base not aligned");

    a_slot_in_table: assert property (@(posedge clock) disable iff (!resetn)
        fetch.valid |-> fetch.addr[7:6] == 2'h0)
        else $error("fetch slot outside table");

    a_trap_slot: assert property (@(posedge clock) disable iff (!resetn)
        trap_taken |=> fetch.addr[7:0] == 8'h20 + {3'h0, $past(trapNumber)})
        else $error("trap slot wrong");

    a_trap_base: assert property (@(posedge clock) disable iff (!resetn)
        (trap_taken and !baseWrite) |=> fetch.addr[23:8] == $past(base))
        else $error("trap base wrong");

    a_source_onehot: assert property (@(posedge clock) disable iff (!resetn)
        source_taken |=> fetch.valid && $onehot(takenSource))
        else $error("taken source not one-hot");

    a_source_base: assert property (@(posedge clock) disable iff (!resetn)
        (source_taken and !baseWrite) |=> fetch.addr[23:8] == vectorTableBasePointer[23:8])
        else $error("interrupt base wrong");

    a_taken_pulse: assert property (@(posedge clock) disable iff (!resetn)
        (|takenSource) && enable |=> takenSource == '0)
        else $error("taken source held too long");

    a_fetch_holds: assert property (@(posedge clock) disable iff (!resetn)
        fetch.valid && !fetchReady && enable |=> fetch.valid && $stable(fetch.addr))
        else $error("fetch dropped before accept");

    a_fetch_release: assert property (@(posedge clock) disable iff (!resetn)
        fetch_accepted |=> !fetch.valid)
        else $error("fetch not released");

    a_base_write: assert property (@(posedge clock) disable iff (!resetn)
        baseWrite && enable |=> vectorTableBasePointer[23:8] == $past(baseData[23:8]))
        else $error("base pointer not updated");

    a_ext0_slot: assert property (@(posedge clock) disable iff (!resetn)
        takenSource[0] |-> fetch.valid && fetch.addr[7:0] == 8'h01)
        else $error("external 0 slot wrong");

    a_dma1_slot: assert property (@(posedge clock) disable iff (!resetn)
        takenSource == 10'h200 |-> fetch.addr[7:0] == 8'h0C)
        else $error("dma 1 slot wrong");

    a_level_follows: assert property (@(posedge clock) disable iff (!resetn)
        enable && !edgeMode[0] && $stable(edgeMode[0]) && externalRequest[0] ##1 enable [*2]
        |-> extPending[0])
        else $error("level request not seen");

endmodule

// *** src/vector_map_pkg.sv ***
package vector_map_pkg;

    // ----------------------------------------
    // address layout
    // ----------------------------------------
    localparam int ADDR_W = 24;
    localparam int SLOT_W = 8;
    localparam int BASE_W = ADDR_W - SLOT_W;
    localparam logic [ADDR_W-1:0] RESET_VECTOR = 24'h00_0000;
    localparam logic [BASE_W-1:0] BASE_RESET = 16'h0000;

    // ----------------------------------------
    // source slot offsets
    // ----------------------------------------
    localparam int NUM_EXT = 4;
    localparam int NUM_SRC = 10;
    localparam logic [SLOT_W-1:0] SLOT_EXT0 = 8'h01;
    localparam logic [SLOT_W-1:0] SLOT_SER_TX = 8'h05;
    localparam logic [SLOT_W-1:0] SLOT_SER_RX = 8'h06;
    localparam logic [SLOT_W-1:0] SLOT_TIMER0 = 8'h09;
    localparam logic [SLOT_W-1:0] SLOT_TIMER1 = 8'h0A;
    localparam logic [SLOT_W-1:0] SLOT_DMA0 = 8'h0B;
    localparam logic [SLOT_W-1:0] SLOT_DMA1 = 8'h0C;
    localparam logic [SLOT_W-1:0] SLOT_TRAP_FIRST = 8'h20;
    localparam logic [SLOT_W-1:0] SLOT_TRAP_LAST = 8'h3F;
    localparam int TRAP_W = 5;

    // request bundle: bit order ext0..3, tx, rx, timer0, timer1, dma0, dma1
    typedef struct packed {
        logic [1:0] dma;
        logic [1:0] timer;
        logic serRx;
        logic serTx;
        logic [NUM_EXT-1:0] ext;
    } request_t;

    // fetch answer
    typedef struct packed {
        logic valid;
        logic [ADDR_W-1:0] addr;
    } fetch_t;

endpackage

// *** src/edge_level_detect.sv ***
`timescale 1ns/1ns
module edge_level_detect
    import vector_map_pkg::*;
#(
    parameter int WIDTH = NUM_EXT
) (
    input wire logic clock,
    input wire logic resetn,
    input wire logic enable,
    input wire logic [WIDTH-1:0] pin,
    input wire logic [WIDTH-1:0] edgeMode,
    input wire logic [WIDTH-1:0] clear,
    output logic [WIDTH-1:0] pending
);

    // ----------------------------------------
    // synchroniser and latch
    // ----------------------------------------
    logic [WIDTH-1:0] sync1, sync2, prev, latched;
    logic [WIDTH-1:0] next_sync1, next_sync2, next_prev, next_latched;

    // edge mode latches a rise, level mode follows the pin
    always_comb begin
        next_sync1 = pin;
        next_sync2 = sync1;
        next_prev = sync2;
        next_latched = latched;
        for (int i = 0; i < WIDTH; i++) begin
            if (edgeMode[i]) begin
                if (sync2[i] && !prev[i]) begin
                    next_latched[i] = 1'b1; // set wins over clear
                end else if (clear[i]) begin
                    next_latched[i] = 1'b0;
                end
            end else begin
                next_latched[i] = 1'b0;
            end
        end
    end

    // state registers
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            sync1 <= '0;
            sync2 <= '0;
            prev <= '0;
            latched <= '0;
        end else if (enable) begin
            sync1 <= next_sync1;
            sync2 <= next_sync2;
            prev <= next_prev;
            latched <= next_latched;
        end
    end

    assign pending = latched | (~edgeMode & sync2);

endmodule

// *** tb/request_source.sv ***
`timescale 1ns/1ns
module request_source
    import vector_map_pkg::*;
(
    input wire logic clock,
    input wire logic resetn,
    input wire logic [NUM_SRC-1:0] raise,
    input wire logic [NUM_SRC-1:0] drop,
    input wire logic [NUM_SRC-1:0] takenSource,
    output logic [NUM_EXT-1:0] externalRequest,
    output request_t peripheralRequest
);
    // ----------------------------------------
    // request lines of the far side
    // ----------------------------------------
    logic [NUM_SRC-1:0] held;

    // a raised level stands until it is served or withdrawn
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            held <= '0;
        end else begin
            held <= (held | raise) & ~(drop | takenSource);
        end
    end

    // pins and on-chip lines, active high
    assign externalRequest = held[NUM_EXT-1:0];
    // the ext field of the bundle carries junk that must be ignored
    assign peripheralRequest = {held[NUM_SRC-1:NUM_EXT], ~held[NUM_EXT-1:0]};
endmodule

// *** tb/tb.sv ***
`timescale 1ns/1ns
`define CHK(n, e, g) begin cmp_count++; if ((g) !== (e)) begin failures++; $display("BAD %s exp %h got %h", n, e, g); end end
module tb;
    import vector_map_pkg::*;
    logic clock = 1'b0;
    logic resetn = 1'b0;
    logic enable = 1'b1;
    logic [NUM_EXT-1:0] edgeMode = '0;
    logic baseWrite = 1'b0;
    logic [ADDR_W-1:0] baseData = '0;
    logic trapRequest = 1'b0;
    logic [TRAP_W-1:0] trapNumber = '0;
    logic fetchReady = 1'b0;
    logic [NUM_SRC-1:0] raise = '0;
    logic [NUM_SRC-1:0] drop = '0;
    logic [NUM_EXT-1:0] externalRequest;
    request_t peripheralRequest;
    logic [NUM_SRC-1:0] pendingSources;
    logic [ADDR_W-1:0] vectorTableBasePointer;
    fetch_t fetch;
    logic [NUM_SRC-1:0] takenSource;
    int failures = 0;
    int cmp_count = 0;
    int seed = 32'h8e19_01f7;
    int expQ[$];
    int base;
    int slotTable[NUM_SRC] = '{1, 2, 3, 4, 5, 6, 9, 10, 11, 12};

    // ----------------------------------------
    // clock, design and far side
    // ----------------------------------------
    always #2 clock = ~clock;

    interrupt_vector_mapper dut (.clock(clock), .resetn(resetn), .enable(enable),
        .externalRequest(externalRequest), .edgeMode(edgeMode), .peripheralRequest(peripheralRequest),
        .baseWrite(baseWrite), .baseData(baseData), .trapRequest(trapRequest), .trapNumber(trapNumber),
        .fetchReady(fetchReady), .pendingSources(pendingSources),
        .vectorTableBasePointer(vectorTableBasePointer), .fetch(fetch), .takenSource(takenSource));

    request_source partner (.clock(clock), .resetn(resetn), .raise(raise), .drop(drop),
        .takenSource(takenSource), .externalRequest(externalRequest), .peripheralRequest(peripheralRequest));

    // ----------------------------------------
    // shared tasks
    // ----------------------------------------
    task automatic tick(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask

    // wait for the fetch, compare with the model, then accept it
    task automatic serve(input logic [NUM_SRC-1:0] src);
        int i;
        int e;
        for (i = 0; i < 20 && fetch.valid !== 1'b1; i++) tick(1);
        e = expQ.pop_front();
        `CHK("fetch valid", 1'b1, fetch.valid)
        `CHK("fetch addr", e[ADDR_W-1:0], fetch.addr)
        `CHK("taken source", src, takenSource)
        fetchReady = 1'b1;
        tick(1);
        fetchReady = 1'b0;
        `CHK("fetch released", 1'b0, fetch.valid)
        tick(1);
    endtask

    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    initial begin
        repeat (12) @(posedge clock);
        #1 resetn = 1'b1;
        expQ.push_back(0);
        serve('0);
        base = $random(seed);
        baseData = base[ADDR_W-1:0];
        baseWrite = 1'b1;
        tick(1);
        baseWrite = 1'b0;
        base = base & 32'h00ff_ff00;
        `CHK("base", base[ADDR_W-1:0], vectorTableBasePointer)
        // a write while the block is frozen must not land
        enable = 1'b0;
        baseData = ~baseData;
        baseWrite = 1'b1;
        tick(2);
        `CHK("frozen base", base[ADDR_W-1:0], vectorTableBasePointer)
        baseWrite = 1'b0;
        enable = 1'b1;
        for (int n = 0; n < 32; n++) begin
            expQ.push_back(base + 32 + n);
            trapNumber = n[TRAP_W-1:0];
            trapRequest = 1'b1;
            tick(1);
            trapRequest = 1'b0;
            serve('0);
        end
        edgeMode = 4'hF;
        for (int i = 0; i < NUM_SRC; i++) begin
            expQ.push_back(base + slotTable[i]);
            raise[i] = 1'b1;
            tick(1);
            raise = '0;
            if (i >= NUM_EXT) begin
                `CHK("pending", NUM_SRC'(1) << i, pendingSources)
            end
            serve(NUM_SRC'(1) << i);
        end
        // short pulse on pin 0 while a fetch is outstanding
        for (int m = 0; m < 2; m++) begin
            edgeMode = {3'b000, m[0]};
            expQ.push_back(base + 32);
            trapNumber = '0;
            trapRequest = 1'b1;
            tick(1);
            trapRequest = 1'b0;
            raise[0] = 1'b1;
            tick(1);
            raise = '0;
            drop[0] = 1'b1;
            tick(1);
            drop = '0;
            tick(4);
            `CHK("pin latch", m[0], pendingSources[0])
            serve('0);
            if (m == 1) begin
                expQ.push_back(base + 1);
                serve(NUM_SRC'(1));
            end else begin
                tick(8);
                `CHK("level gone", 1'b0, fetch.valid)
            end
        end
        resetn = 1'b0;
        tick(1);
        `CHK("reset addr", 24'h00_0000, fetch.addr)
        `CHK("reset base", 24'h00_0000, vectorTableBasePointer)
        resetn = 1'b1;
        tick(2);
        `CHK("reset fetch stands", 1'b1, fetch.valid)
        `CHK("reset fetch addr", 24'h00_0000, fetch.addr)
        report_and_stop();
    end

    // watchdog on a hang
    initial begin
        #20000;
        failures++;
        report_and_stop();
    end
endmodule
